// ===== rtl/pdt_regs.sv
// Top of the clock loop divider, oscillator bias, lane emphasis and trigger output register bank.
// Assumes the loop hold reset and serializer strobes come from logic on CLK_I; pins are asynchronous.
//
// What this block does
// [R1] Second divider code: 1, 2, 4; 3 reserved
// [R2] First divider code: 5, 4, 3; 3 reserved
// [R3] Third divider divides by value, 1 to 63
// [R4] Software holds loop reset while changing dividers
// [R5] Software writes reserved fields as zero
// [R6] Software programs oscillator bias 0x4A, not 0x4F
// [R7] One emphasis level drives all eight lanes
// [R8] Enable bit 7 gates trigger buffer, divider
// [R9] Select: 16, 32, 64 UI, timestamp; rest reserved
// [R10] Software changes select only while disabled
// [R11] UI clocks derive from serializer; reinit disrupts
// [R12] Total ratio is product of three dividers
`timescale 1ns/1ps
`default_nettype none

module pdt_regs
   import pdt_pkg::*;
(
   input  wire logic          CLK_I,                   // 200 MHz system clock
   input  wire logic          NRST_I,                  // Asynchronous reset, active low
   input  wire logic          CE_I,                    // Clock enable
   input  wire logic          SPI_SCLK_I,              // Serial control clock pin
   input  wire logic          SPI_CS_N_I,              // Serial chip select pin, active low
   input  wire logic          SPI_SDI_I,               // Serial data in pin
   output logic               SPI_SDO_O,               // Serial data out
   output logic               SPI_SDO_OE_N_O,          // Serial data out enable, active low
   input  wire logic          LOOP_HOLD_RESET_I,       // Clock loop held in reset
   input  wire logic          SER_UI_TICK_I,           // One pulse per serializer UI
   input  wire logic          SER_REINIT_I,            // Serializer re-initialising
   input  wire logic          TIMESTAMP_PULSE_INPUT_I, // Timestamp pin
   output logic [2:0]         FB_V_RATIO_O,            // Applied first divider ratio
   output logic [2:0]         FB_P_RATIO_O,            // Applied second divider ratio
   output logic [5:0]         FB_N_RATIO_O,            // Applied third divider ratio
   output logic [4:0]         FB_SAMPLE_RATIO_O,       // Oscillator to sampling clock ratio
   output logic [10:0]        FB_TOTAL_RATIO_O,        // Oscillator to phase detector ratio
   output logic [6:0]         OSC_BIAS_LEVEL_O,        // Oscillator bias level
   output logic [31:0]        LANE_EMPHASIS_LEVEL_O,   // Four bits per lane, lane 0 lowest
   output logic               TRIG_OUT_ENABLE_O,       // Trigger buffer enabled
   output logic               TRIG_CLOCK_OUTPUT_O      // Trigger output level
);

   // ==========================================================
   // Serial control port
   pdt_reg_req_t req;      // Address and write strobe
   logic [7:0]   rdata;    // Read data for the latched address

   pdt_spi_port u_spi (
      .clk_i      (CLK_I),
      .rst_n_i    (NRST_I),
      .ce_i       (CE_I),
      .sclk_i     (SPI_SCLK_I),
      .cs_n_i     (SPI_CS_N_I),
      .sdi_i      (SPI_SDI_I),
      .rdata_i    (rdata),
      .req_o      (req),
      .sdo_o      (SPI_SDO_O),
      .sdo_oe_n_o (SPI_SDO_OE_N_O)
   );

   // ==========================================================
   // Register storage
   logic [7:0] fb_vp;     // pll_feedback_vp_divider
   logic [7:0] fb_n;      // pll_feedback_n_divider
   logic [7:0] osc_bias;  // oscillator_bias_control
   logic [7:0] emph;      // lane_preemphasis_control
   logic [7:0] trig;      // trigger_output_control

   // Whole bytes stored; reserved bits read back as written, zero expected [R5]
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         fb_vp    <= RST_FB_VP;
         fb_n     <= RST_FB_N;
         osc_bias <= RST_OSC;        // Power-up bias; software must replace it [R6]
         emph     <= RST_EMPH;
         trig     <= RST_TRIG;       // Trigger output starts disabled [R8]
      end else if (CE_I && req.wr) begin
         case (req.addr)
            ADDR_FB_VP: fb_vp    <= req.wdata;
            ADDR_FB_N:  fb_n     <= req.wdata;
            ADDR_OSC:   osc_bias <= req.wdata;
            ADDR_EMPH:  emph     <= req.wdata;
            ADDR_TRIG:  trig     <= req.wdata;
            default:    ;          // Unmapped writes are dropped
         endcase
      end
   end

   // Read mux, registered; address is stable long before data shifts out
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rdata <= RD_UNMAPPED;
      end else if (CE_I) begin
         case (req.addr)
            ADDR_FB_VP: rdata <= fb_vp;
            ADDR_FB_N:  rdata <= fb_n;
            ADDR_OSC:   rdata <= osc_bias;
            ADDR_EMPH:  rdata <= emph;
            ADDR_TRIG:  rdata <= trig;
            default:    rdata <= RD_UNMAPPED;
         endcase
      end
   end

   // ==========================================================
   // Clock loop feedback dividers
   logic [2:0]  next_v;      // Decoded first divider ratio
   logic [2:0]  next_p;      // Decoded second divider ratio
   logic [5:0]  next_n;      // Third divider value
   logic        loop_ok;     // All three settings legal
   logic [4:0]  next_samp;   // First times second
   logic [10:0] next_total;  // All three multiplied

   // Decode the programmed codes
   always_comb begin
      next_v     = v_ratio(fb_vp[V_LSB +: 2]);          // [R2]
      next_p     = p_ratio(fb_vp[P_LSB +: 2]);          // [R1]
      next_n     = fb_n[N_LSB +: 6];                    // [R3]
      loop_ok    = (next_v != 3'h0) && (next_p != 3'h0) && (next_n != 6'h00);
      next_samp  = 5'(next_v) * 5'(next_p);             // [R12]
      next_total = 11'(next_samp) * 11'(next_n);        // [R12]
   end

   // Settings reach the loop only while it is held in reset, so a divider
   // never changes under a running loop; reserved codes and zero are ignored
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         FB_V_RATIO_O      <= RST_V_RATIO;
         FB_P_RATIO_O      <= RST_P_RATIO;
         FB_N_RATIO_O      <= RST_N_RATIO;
         FB_SAMPLE_RATIO_O <= 5'(RST_V_RATIO) * 5'(RST_P_RATIO);
         FB_TOTAL_RATIO_O  <= 11'(RST_V_RATIO) * 11'(RST_P_RATIO) * 11'(RST_N_RATIO);
      end else if (CE_I && LOOP_HOLD_RESET_I && loop_ok) begin   // [R4]
         FB_V_RATIO_O      <= next_v;                            // [R2]
         FB_P_RATIO_O      <= next_p;                            // [R1]
         FB_N_RATIO_O      <= next_n;                            // [R3]
         FB_SAMPLE_RATIO_O <= next_samp;                         // [R1]
         FB_TOTAL_RATIO_O  <= next_total;                        // [R12]
      end
   end

   // ==========================================================
   // Oscillator bias and lane emphasis
   // Bias follows the register at once; the recommended value is software's job
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         OSC_BIAS_LEVEL_O      <= RST_OSC[BIAS_LSB +: 7];
         LANE_EMPHASIS_LEVEL_O <= {LANES{RST_EMPH[EMPH_LSB +: 4]}};
      end else if (CE_I) begin
         OSC_BIAS_LEVEL_O      <= osc_bias[BIAS_LSB +: 7];
         LANE_EMPHASIS_LEVEL_O <= {LANES{emph[EMPH_LSB +: 4]}};   // [R7]
      end
   end

   // ==========================================================
   // Trigger output
   logic       trig_en;     // Enable bit
   logic [2:0] trig_sel;    // Select field
   logic [4:0] half;        // UI ticks per half period, minus one
   assign trig_en  = trig[TEN_BIT];
   assign trig_sel = trig[TSEL_LSB +: 3];

   // Half period lookup, minus one since the counter starts at zero
   always_comb begin
      case (trig_sel)
         TSEL_UI16: half = HALF_UI16 - 5'h01;                    // [R9]
         TSEL_UI32: half = HALF_UI32 - 5'h01;                    // [R9]
         TSEL_UI64: half = 5'(HALF_UI64 - 6'h01);                // [R9]
         default:   half = 5'h1f;
      endcase
   end

   // Timestamp pin synchroniser; stable copy is the resampled stamp
   logic ts_m, ts_s;
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ts_m <= 1'b0;
         ts_s <= 1'b0;
      end else if (CE_I) begin
         ts_m <= TIMESTAMP_PULSE_INPUT_I;
         ts_s <= ts_m;
      end
   end

   // UI divider counts serializer ticks; a reinit restarts it, so the
   // output briefly stops rather than carrying a stale phase
   logic [4:0] ui_cnt;   // Ticks in this half period
   logic       ui_clk;   // Divided clock level
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ui_cnt <= 5'h00;
         ui_clk <= 1'b0;
      end else if (CE_I) begin
         if (!trig_en || SER_REINIT_I) begin         // [R8] [R11]
            ui_cnt <= 5'h00;                         // [R10]
            ui_clk <= 1'b0;
         end else if (trig_sel <= TSEL_UI64 && SER_UI_TICK_I) begin   // [R11]
            if (ui_cnt == half) begin
               ui_cnt <= 5'h00;
               ui_clk <= ~ui_clk;                    // [R9]
            end else begin
               ui_cnt <= ui_cnt + 5'h01;
            end
         end
      end
   end

   // Output mux, registered; reserved selects hold the output low
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         TRIG_OUT_ENABLE_O   <= 1'b0;
         TRIG_CLOCK_OUTPUT_O <= 1'b0;
      end else if (CE_I) begin
         TRIG_OUT_ENABLE_O <= trig_en;               // [R8]
         if (!trig_en) begin
            TRIG_CLOCK_OUTPUT_O <= 1'b0;             // [R8]
         end else begin
            case (trig_sel)
               TSEL_UI16, TSEL_UI32, TSEL_UI64: TRIG_CLOCK_OUTPUT_O <= ui_clk;   // [R11]
               TSEL_STAMP:                      TRIG_CLOCK_OUTPUT_O <= ts_s;     // [R9]
               default:                         TRIG_CLOCK_OUTPUT_O <= 1'b0;     // [R9]
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ===== common/pdt_pkg.sv
// Shared constants, types and helpers for the clock loop divider and trigger output register bank.
// Assumes an 8-bit register file behind a 15-bit serial control port address.
`default_nettype none

package pdt_pkg;

   // ==========================================================
   // Serial control port framing
   localparam int ADDR_W      = 15;          // Register address width
   localparam int DATA_W      = 8;           // Register data width
   localparam logic [4:0] ADDR_DONE_BITS = 5'h10;   // Direction bit plus address
   localparam logic [4:0] FRAME_BITS     = 5'h18;   // Whole single-register frame

   // ==========================================================
   // Register offsets
   localparam logic [14:0] ADDR_FB_VP   = 15'h003d;  // pll_feedback_vp_divider
   localparam logic [14:0] ADDR_FB_N    = 15'h003e;  // pll_feedback_n_divider
   localparam logic [14:0] ADDR_OSC     = 15'h003f;  // oscillator_bias_control
   localparam logic [14:0] ADDR_EMPH    = 15'h0048;  // lane_preemphasis_control
   localparam logic [14:0] ADDR_TRIG    = 15'h0057;  // trigger_output_control

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_FB_VP     = 8'h00;
   localparam logic [7:0] RST_FB_N      = 8'h20;
   localparam logic [7:0] RST_OSC       = 8'h4f;
   localparam logic [7:0] RST_EMPH      = 8'h00;
   localparam logic [7:0] RST_TRIG      = 8'h00;
   localparam logic [7:0] RD_UNMAPPED   = 8'h00;     // Answer for unmapped reads

   // ==========================================================
   // Field positions
   localparam int V_LSB    = 0;   // First feedback divider code, 1:0
   localparam int P_LSB    = 2;   // Second feedback divider code, 3:2
   localparam int N_LSB    = 0;   // Third feedback divider value, 5:0
   localparam int BIAS_LSB = 0;   // Oscillator bias level, 6:0
   localparam int EMPH_LSB = 0;   // Lane emphasis level, 3:0
   localparam int TEN_BIT  = 7;   // Trigger output enable
   localparam int TSEL_LSB = 0;   // Trigger output select, 2:0
   localparam int LANES    = 8;   // Serial output lanes sharing emphasis

   // Loop ratio values applied after reset
   localparam logic [2:0]  RST_V_RATIO = 3'h5;
   localparam logic [2:0]  RST_P_RATIO = 3'h1;
   localparam logic [5:0]  RST_N_RATIO = 6'h20;

   // ==========================================================
   // Trigger output select codes
   typedef enum logic [2:0] {
      TSEL_UI16  = 3'b000,
      TSEL_UI32  = 3'b001,
      TSEL_UI64  = 3'b010,
      TSEL_STAMP = 3'b011
   } pdt_trig_sel_t;

   // Half periods of the UI clocks, in UI ticks
   localparam logic [4:0] HALF_UI16 = 5'h08;
   localparam logic [4:0] HALF_UI32 = 5'h10;
   localparam logic [5:0] HALF_UI64 = 6'h20;  // Wider, 32 does not fit five bits

   // Register write request from the serial port
   typedef struct packed {
      logic              wr;     // One-cycle write strobe
      logic [14:0]       addr;   // Latched address
      logic [7:0]        wdata;  // Write data
   } pdt_reg_req_t;

   // ==========================================================
   // First divider code to ratio, zero for the reserved code
   function automatic logic [2:0] v_ratio(input logic [1:0] code);
      case (code)
         2'h0:    v_ratio = 3'h5;
         2'h1:    v_ratio = 3'h4;
         2'h2:    v_ratio = 3'h3;
         default: v_ratio = 3'h0;
      endcase
   endfunction

   // Second divider code to ratio, zero for the reserved code
   function automatic logic [2:0] p_ratio(input logic [1:0] code);
      case (code)
         2'h0:    p_ratio = 3'h1;
         2'h1:    p_ratio = 3'h2;
         2'h2:    p_ratio = 3'h4;
         default: p_ratio = 3'h0;
      endcase
   endfunction

endpackage

`default_nettype wire

// ===== rtl/pdt_spi_port.sv
// Serial control port slave: 24-bit frames, direction bit, 15-bit address, 8 data bits, MSB first.
// Assumes serial clock and chip select are asynchronous to clk_i and much slower than it.
`timescale 1ns/1ps
`default_nettype none

module pdt_spi_port
   import pdt_pkg::*;
(
   input  wire logic         clk_i,      // System clock
   input  wire logic         rst_n_i,    // Asynchronous reset, active low
   input  wire logic         ce_i,       // Clock enable, freezes all state
   input  wire logic         sclk_i,     // Serial clock pin
   input  wire logic         cs_n_i,     // Chip select pin, active low
   input  wire logic         sdi_i,      // Serial data in pin
   input  wire logic [7:0]   rdata_i,    // Read data for the latched address
   output var pdt_reg_req_t  req_o,      // Address and write strobe
   output logic              sdo_o,      // Serial data out
   output logic              sdo_oe_n_o  // Output enable, low while driving
);

   // ==========================================================
   // Pin synchronisers
   logic sclk_m, sclk_s, sclk_d;   // Serial clock: meta, stable, delayed
   logic cs_m, cs_s;               // Chip select
   logic sdi_m, sdi_s;             // Serial data

   // Two flops per pin, three on the serial clock; only stable copies feed logic
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         cs_m   <= 1'b1;
         cs_s   <= 1'b1;
         sdi_m  <= 1'b0;
         sdi_s  <= 1'b0;
      end else if (ce_i) begin
         sclk_m <= sclk_i;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         cs_m   <= cs_n_i;
         cs_s   <= cs_m;
         sdi_m  <= sdi_i;
         sdi_s  <= sdi_m;
      end
   end

   logic sclk_rise;   // Serial clock rising edge seen
   logic sclk_fall;   // Serial clock falling edge seen
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;

   // ==========================================================
   // Frame receive
   logic [4:0]  bit_cnt;    // Rising edges in this frame, saturates
   logic [22:0] shift_in;   // Received bits
   logic        is_read;    // Direction bit of this frame

   // Count and shift; a frame is cut short by chip select going high
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt  <= 5'h00;
         shift_in <= 23'h00_0000;
      end else if (ce_i) begin
         if (cs_s) begin
            bit_cnt <= 5'h00;
         end else if (sclk_rise && bit_cnt != FRAME_BITS) begin
            bit_cnt  <= bit_cnt + 5'h01;
            shift_in <= {shift_in[21:0], sdi_s};
         end
      end
   end

   // Address latch and write strobe; writes only after all 24 bits
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_o   <= '0;
         is_read <= 1'b0;
      end else if (ce_i) begin
         req_o.wr <= 1'b0;
         if (!cs_s && sclk_rise) begin
            if (bit_cnt == ADDR_DONE_BITS - 5'h01) begin
               req_o.addr <= {shift_in[13:0], sdi_s};
               is_read    <= shift_in[14];
            end else if (bit_cnt == FRAME_BITS - 5'h01 && !is_read) begin
               req_o.wr    <= 1'b1;
               req_o.wdata <= {shift_in[6:0], sdi_s};
            end
         end
      end
   end

   // ==========================================================
   // Read data out, changing on falling serial clock edges
   logic [7:0] tx;   // Remaining read bits

   // First bit goes out on the fall right after the address
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx         <= 8'h00;
         sdo_o      <= 1'b0;
         sdo_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         if (cs_s) begin
            sdo_o      <= 1'b0;
            sdo_oe_n_o <= 1'b1;
         end else begin
            sdo_oe_n_o <= ~(is_read && bit_cnt >= ADDR_DONE_BITS);
            if (sclk_fall && is_read && bit_cnt == ADDR_DONE_BITS) begin
               sdo_o <= rdata_i[7];
               tx    <= {rdata_i[6:0], 1'b0};
            end else if (sclk_fall && is_read && bit_cnt > ADDR_DONE_BITS) begin
               sdo_o <= tx[7];
               tx    <= {tx[6:0], 1'b0};
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== tb/pdt_regs_asserts.sv
// Concurrent checks on the register bank's top-level ports.
// Assumes binding onto pdt_regs; one clock domain, asynchronous active low reset.
`timescale 1ns/1ps
`default_nettype none

module pdt_regs_asserts
   import pdt_pkg::*;
(
   input wire logic        CLK_I,
   input wire logic        NRST_I,
   input wire logic        LOOP_HOLD_RESET_I,
   input wire logic        SPI_SDO_OE_N_O,
   input wire logic [2:0]  FB_V_RATIO_O,
   input wire logic [2:0]  FB_P_RATIO_O,
   input wire logic [5:0]  FB_N_RATIO_O,
   input wire logic [4:0]  FB_SAMPLE_RATIO_O,
   input wire logic [10:0] FB_TOTAL_RATIO_O,
   input wire logic [31:0] LANE_EMPHASIS_LEVEL_O,
   input wire logic        TRIG_OUT_ENABLE_O,
   input wire logic        TRIG_CLOCK_OUTPUT_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);

   // ==========================================================
   // Helper: cycles the applied ratios have held still
   logic [11:0] ratios_q;   // Ratios seen last cycle
   logic [1:0]  still_cnt;  // Saturating stability count
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ratios_q  <= 12'h000;
         still_cnt <= 2'h0;
      end else begin
         ratios_q <= {FB_V_RATIO_O, FB_P_RATIO_O, FB_N_RATIO_O};
         // Products may lag the ratios, so wait for them to settle
         if (ratios_q != {FB_V_RATIO_O, FB_P_RATIO_O, FB_N_RATIO_O}) begin
            still_cnt <= 2'h0;
         end else if (still_cnt != 2'h3) begin
            still_cnt <= still_cnt + 2'h1;
         end
      end
   end

   // ==========================================================
   // Assertions
   AST_V_SET: assert property (FB_V_RATIO_O inside {3'h3, 3'h4, 3'h5})
      else $error("first divider ratio outside 3 to 5");
   AST_P_SET: assert property (FB_P_RATIO_O inside {3'h1, 3'h2, 3'h4})
      else $error("second divider ratio outside 1, 2, 4");
   AST_N_NONZERO: assert property (FB_N_RATIO_O != 6'h00)
      else $error("third divider ratio is zero");
   AST_SAMPLE: assert property (still_cnt >= 2'h2 |-> FB_SAMPLE_RATIO_O == FB_V_RATIO_O * FB_P_RATIO_O)
      else $error("sampling ratio not first times second");
   AST_TOTAL: assert property (still_cnt >= 2'h2 |->
      FB_TOTAL_RATIO_O == FB_V_RATIO_O * FB_P_RATIO_O * FB_N_RATIO_O)
      else $error("total ratio not product of three dividers");
   AST_HOLD: assert property (!$past(LOOP_HOLD_RESET_I) |->
      $stable({FB_V_RATIO_O, FB_P_RATIO_O, FB_N_RATIO_O}))
      else $error("divider ratios moved while loop running");
   AST_LANES: assert property (LANE_EMPHASIS_LEVEL_O == {8{LANE_EMPHASIS_LEVEL_O[3:0]}})
      else $error("lanes carry different emphasis levels");
   AST_TRIG_OFF: assert property (!TRIG_OUT_ENABLE_O && !$past(TRIG_OUT_ENABLE_O) |-> !TRIG_CLOCK_OUTPUT_O)
      else $error("trigger output active while disabled");

   // Main scenarios reached
   cover property ($rose(TRIG_CLOCK_OUTPUT_O));
   cover property (LOOP_HOLD_RESET_I && FB_V_RATIO_O == 3'h3);
   cover property ($fell(SPI_SDO_OE_N_O));
endmodule

bind pdt_regs pdt_regs_asserts chk_u (.*);
`default_nettype wire

// ===== tb/pdt_regs_bench.sv
// Self-checking bench for the register bank, driving the serial port and side inputs.
// Assumes pdt_regs and its bound checker; inputs change at falling edges of CLK_I.
`timescale 1ns/1ps
`default_nettype none

module pdt_regs_bench;
   import pdt_pkg::*;
   logic        CLK_I = 1'b0, NRST_I = 1'b0, CE_I = 1'b1;
   logic        SPI_SCLK_I = 1'b0, SPI_CS_N_I = 1'b1, SPI_SDI_I = 1'b0, SPI_SDO_O, SPI_SDO_OE_N_O;
   logic        LOOP_HOLD_RESET_I = 1'b0, SER_UI_TICK_I = 1'b0, SER_REINIT_I = 1'b0;
   logic        TIMESTAMP_PULSE_INPUT_I = 1'b0, TRIG_OUT_ENABLE_O, TRIG_CLOCK_OUTPUT_O;
   logic [2:0]  FB_V_RATIO_O, FB_P_RATIO_O;
   logic [5:0]  FB_N_RATIO_O;
   logic [4:0]  FB_SAMPLE_RATIO_O;
   logic [10:0] FB_TOTAL_RATIO_O;
   logic [6:0]  OSC_BIAS_LEVEL_O;
   logic [31:0] LANE_EMPHASIS_LEVEL_O;
   int          fails = 0, checked = 0;  // Mismatch and comparison counts

   pdt_regs dut_u (.*);

   // 200 MHz clock
   always #2.5 CLK_I = ~CLK_I;

   // ==========================================================
   // Shared tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One 24-bit frame; six system cycles per serial half period keeps the synchronisers happy
   task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] rdd);
      logic [23:0] f;
      f = {rd, a, wd};
      rdd = 8'h00;
      SPI_CS_N_I = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         SPI_SDI_I = f[i];
         repeat (6) @(negedge CLK_I);
         if (i < 8) rdd[i] = SPI_SDO_OE_N_O ? 1'bx : SPI_SDO_O;  // Driven, settled since the fall
         SPI_SCLK_I = 1'b1;
         repeat (6) @(negedge CLK_I);
         SPI_SCLK_I = 1'b0;
      end
      repeat (6) @(negedge CLK_I);
      SPI_CS_N_I = 1'b1;
      repeat (8) @(negedge CLK_I);
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      spi(1'b0, a, d, dummy);
   endtask

   task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
      logic [7:0] got;
      spi(1'b1, a, 8'h00, got);
      check("readback", got, exp);
   endtask

   // Disable, move the select, enable: the select never moves while enabled
   logic [2:0] sel_now = 3'h0;  // Select last written
   task automatic trig_on(input logic [2:0] s);
      wr(15'h0057, {5'h00, sel_now});
      wr(15'h0057, {5'h00, s});
      wr(15'h0057, {5'h10, s});
      sel_now = s;
   endtask

   // Serializer UI pulses, then room for the output register
   task automatic tick(input int n);
      repeat (n) begin
         SER_UI_TICK_I = 1'b1;
         @(negedge CLK_I);
         SER_UI_TICK_I = 1'b0;
         @(negedge CLK_I);
      end
      repeat (3) @(negedge CLK_I);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      logic [14:0] ad[6] = '{15'h003d, 15'h003e, 15'h003f, 15'h0048, 15'h0057, 15'h0040};
      logic [7:0]  ex[6] = '{8'h00, 8'h20, 8'h4f, 8'h00, 8'h00, 8'h00};
      check("v_rst", FB_V_RATIO_O, 5);
      check("total_rst", FB_TOTAL_RATIO_O, 160);
      check("bias_rst", OSC_BIAS_LEVEL_O, 7'h4f);
      check("trig_rst", {TRIG_OUT_ENABLE_O, TRIG_CLOCK_OUTPUT_O}, 0);
      for (int i = 0; i < 6; i++) rd_chk(ad[i], ex[i]);
   endtask

   task automatic t_div();
      int vr[3] = '{5, 4, 3};
      int pr[3] = '{1, 2, 4};
      LOOP_HOLD_RESET_I = 1'b1;
      for (int v = 0; v < 3; v++) begin
         for (int p = 0; p < 3; p++) begin
            wr(15'h003d, 8'((p << 2) | v));
            check("v_ratio", FB_V_RATIO_O, vr[v]);
            check("p_ratio", FB_P_RATIO_O, pr[p]);
            check("sample", FB_SAMPLE_RATIO_O, vr[v] * pr[p]);
         end
      end
      wr(15'h003e, 8'h3f);
      check("n_63", FB_N_RATIO_O, 63);
      check("total_63", FB_TOTAL_RATIO_O, 756);
      wr(15'h003e, 8'h01);
      check("total_1", FB_TOTAL_RATIO_O, 12);
      wr(15'h003d, 8'h0c);
      check("p_resv", FB_P_RATIO_O, 4);
      LOOP_HOLD_RESET_I = 1'b0;
      wr(15'h003d, 8'h00);
      wr(15'h003e, 8'h20);
      check("v_running", FB_V_RATIO_O, 3);
      rd_chk(15'h003d, 8'h00);
      LOOP_HOLD_RESET_I = 1'b1;
      repeat (4) @(negedge CLK_I);
      check("total_back", FB_TOTAL_RATIO_O, 160);
      LOOP_HOLD_RESET_I = 1'b0;
   endtask

   task automatic t_bias_lanes();
      wr(15'h003f, 8'h4a);
      check("bias", OSC_BIAS_LEVEL_O, 7'h4a);
      wr(15'h0048, 8'h0b);
      check("lanes", LANE_EMPHASIS_LEVEL_O, 32'hbbbb_bbbb);
      rd_chk(15'h0048, 8'h0b);
   endtask

   task automatic t_trig();
      int h[3] = '{8, 16, 32};
      for (int s = 0; s < 3; s++) begin
         trig_on(3'(s));
         check("trig_en", TRIG_OUT_ENABLE_O, 1);
         tick(h[s] - 1);
         check("trig_early", TRIG_CLOCK_OUTPUT_O, 0);
         tick(1);
         check("trig_first", TRIG_CLOCK_OUTPUT_O, 1);
         tick(h[s]);
         check("trig_second", TRIG_CLOCK_OUTPUT_O, 0);
      end
      trig_on(3'h3);
      TIMESTAMP_PULSE_INPUT_I = 1'b1;
      repeat (6) @(negedge CLK_I);
      check("stamp_hi", TRIG_CLOCK_OUTPUT_O, 1);
      TIMESTAMP_PULSE_INPUT_I = 1'b0;
      repeat (6) @(negedge CLK_I);
      check("stamp_lo", TRIG_CLOCK_OUTPUT_O, 0);
      for (int s = 4; s < 8; s++) begin
         trig_on(3'(s));
         tick(32);
         check("trig_resv", TRIG_CLOCK_OUTPUT_O, 0);
      end
      trig_on(3'h0);
      tick(8);
      wr(15'h0057, 8'h00);
      check("trig_off", TRIG_CLOCK_OUTPUT_O, 0);
      wr(15'h0057, 8'h80);
      tick(8);
      check("trig_restart", TRIG_CLOCK_OUTPUT_O, 1);
      SER_REINIT_I = 1'b1;
      repeat (3) @(negedge CLK_I);
      check("trig_reinit", TRIG_CLOCK_OUTPUT_O, 0);
      SER_REINIT_I = 1'b0;
      rd_chk(15'h0057, 8'h80);
   endtask

   // ==========================================================
   // Verdict, reached from the main sequence or the watchdog
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Watchdog well above the roughly 17000 cycles the scenarios need
   initial begin
      repeat (80000) @(posedge CLK_I);
      fails++;
      end_sim();
   end

   initial begin
      repeat (12) @(negedge CLK_I);
      NRST_I = 1'b1;
      repeat (4) @(negedge CLK_I);
      t_reset();
      t_div();
      t_bias_lanes();
      t_trig();
      end_sim();
   end
endmodule
`default_nettype wire
